// ===== core/ddrcd_ctrl_end.sv
`include "ddrcd_defines.svh"

module ddrcd_ctrl_end (
    input  wire logic                     clk_sys_i,
    input  wire logic                     reset_n_i,
    ddrcd_link_if.ctrl                    link,
    input  wire logic                     req_valid_i,
    input  ddrcd_pkg::ddrcd_cmd_type      req_cmd_i,
    input  wire logic [`DDRCD_BA_W-1:0]   req_ba_i,
    input  wire logic [`DDRCD_ADDR_W-1:0] req_addr_i,
    input  wire logic                     odt_i,
    output logic                          req_taken_o,
    output logic                          req_refused_o
);
    import ddrcd_pkg::*;

    logic [3:0]              div_cnt;
    logic                    launch;
    ddrcd_pstate_type        pstate;
    logic [`DDRCD_NBANK-1:0] open_banks;
    logic [3:0]              cke_hold;
    logic [7:0]              xs_cnt;
    logic [7:0]              xsdll_cnt;
    logic                    need_cke;
    logic                    bad;
    logic                    hold_off;
    logic                    go;

    // ---------------------------------------------------------------
    // link clock divider; pins change on the falling edge
    // ---------------------------------------------------------------
    assign launch = (div_cnt == `DDRCD_CK_HALF) && link.ck;

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            div_cnt      <= 4'h0;
            link.ck      <= 1'b0;
            link.reset_n <= 1'b0;
        end else begin
            link.reset_n <= 1'b1;
            if (div_cnt == `DDRCD_CK_HALF) begin
                div_cnt <= 4'h0;
                link.ck <= ~link.ck;
            end else begin
                div_cnt <= div_cnt + 4'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // request check
    // ---------------------------------------------------------------
    always_comb begin
        need_cke = (req_cmd_i == C_PDE) || (req_cmd_i == C_SRE) ||
                   (req_cmd_i == C_PDX) || (req_cmd_i == C_SRX);
        case (req_cmd_i)
            C_PDX:   bad = pstate != PS_PD;
            C_SRX:   bad = pstate != PS_SREF;
            C_SRE:   bad = (pstate != PS_AWAKE) || (open_banks != '0);
            C_BAD:   bad = 1'b1;
            default: bad = pstate != PS_AWAKE;
        endcase
        hold_off = (need_cke && cke_hold != 4'h0) ||
                   (xs_cnt != 8'h00 && req_cmd_i != C_NOP) ||
                   (req_cmd_i == C_RD && xsdll_cnt != 8'h00);
        go = launch && req_valid_i && !bad && !hold_off;
    end

    // ---------------------------------------------------------------
    // command pins
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            link.cke   <= 1'b0;
            link.cs_n  <= 1'b1;
            link.ras_n <= 1'b1;
            link.cas_n <= 1'b1;
            link.we_n  <= 1'b1;
            link.odt   <= 1'b0;
            link.ba    <= '0;
            link.addr  <= '0;
        end else if (launch) begin
            link.cs_n  <= 1'b1;
            link.ras_n <= 1'b1;
            link.cas_n <= 1'b1;
            link.we_n  <= 1'b1;
            link.odt   <= odt_i && (pstate != PS_SREF);
            if (go) begin
                link.cs_n <= 1'b0;
                link.ba   <= req_ba_i;
                link.addr <= req_addr_i;
                case (req_cmd_i)
                    C_MRS: {link.ras_n, link.cas_n, link.we_n} <= 3'h0;
                    C_REF: {link.ras_n, link.cas_n, link.we_n} <= 3'h1;
                    C_SRE: begin
                        {link.ras_n, link.cas_n, link.we_n} <= 3'h1;
                        link.cke <= 1'b0;
                    end
                    C_PRE, C_PREA: begin
                        {link.ras_n, link.cas_n, link.we_n} <= 3'h2;
                        link.addr[`DDRCD_A10] <= req_cmd_i == C_PREA;
                    end
                    C_ACT: {link.ras_n, link.cas_n, link.we_n} <= 3'h3;
                    C_WR:  {link.ras_n, link.cas_n, link.we_n} <= 3'h4;
                    C_RD:  {link.ras_n, link.cas_n, link.we_n} <= 3'h5;
                    C_ZQCL, C_ZQCS: begin
                        {link.ras_n, link.cas_n, link.we_n} <= 3'h6;
                        link.addr[`DDRCD_A10] <= req_cmd_i == C_ZQCL;
                    end
                    C_PDE:   link.cke <= 1'b0;
                    C_PDX:   link.cke <= 1'b1;
                    C_SRX:   link.cke <= 1'b1;
                    default: ;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // controller view of state and timers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            pstate     <= PS_PD;
            open_banks <= '0;
        end else if (go) begin
            case (req_cmd_i)
                C_PDE:   pstate <= PS_PD;
                C_SRE:   pstate <= PS_SREF;
                C_PDX:   pstate <= PS_AWAKE;
                C_SRX:   pstate <= PS_AWAKE;
                C_ACT:   open_banks[req_ba_i] <= 1'b1;
                C_PRE:   open_banks[req_ba_i] <= 1'b0;
                C_PREA:  open_banks <= '0;
                C_RD, C_WR: begin
                    if (req_addr_i[`DDRCD_A10]) begin
                        open_banks[req_ba_i] <= 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            cke_hold  <= `DDRCD_TCKE_CK;
            xs_cnt    <= 8'h00;
            xsdll_cnt <= 8'h00;
        end else if (launch) begin
            if (go && need_cke) begin
                cke_hold <= `DDRCD_TCKE_CK;
            end else if (cke_hold != 4'h0) begin
                cke_hold <= cke_hold - 4'h1;
            end
            if (go && req_cmd_i == C_SRX) begin
                xs_cnt    <= `DDRCD_TXS_CK;
                xsdll_cnt <= `DDRCD_TXSDLL_CK;
            end else begin
                if (xs_cnt != 8'h00) begin
                    xs_cnt <= xs_cnt - 8'h01;
                end
                if (xsdll_cnt != 8'h00) begin
                    xsdll_cnt <= xsdll_cnt - 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            req_taken_o   <= 1'b0;
            req_refused_o <= 1'b0;
        end else begin
            req_taken_o   <= go;
            req_refused_o <= launch && req_valid_i && bad;
        end
    end
endmodule : ddrcd_ctrl_end

// ===== core/ddrcd_defines.svh
`ifndef DDRCD_DEFINES_SVH
`define DDRCD_DEFINES_SVH

// ---------------------------------------------------------------
// link widths and fields
// ---------------------------------------------------------------
`define DDRCD_BA_W      3
`define DDRCD_ADDR_W    15
`define DDRCD_NBANK     8
`define DDRCD_A10       10
`define DDRCD_A12       12
`define DDRCD_NCMD      15
`define DDRCD_SYNC_W    25

// ---------------------------------------------------------------
// mode register burst field
// ---------------------------------------------------------------
`define DDRCD_MR0_BA    3'h0
`define DDRCD_BL_LSB    0
`define DDRCD_BL_OTF    2'h1
`define DDRCD_BL_FIX4   2'h2

// ---------------------------------------------------------------
// timing, in link clock cycles (divider in system clocks)
// ---------------------------------------------------------------
`define DDRCD_CK_HALF   4'h7
`define DDRCD_TCKE_CK   4'h3
`define DDRCD_TXS_CK    8'h05
`define DDRCD_TXSDLL_CK 8'h10
`define DDRCD_TXP_CK    8'h03
`define DDRCD_TRFC_CK   8'h08
`define DDRCD_TZQL_CK   8'h10
`define DDRCD_TZQS_CK   8'h04
`define DDRCD_TMRD_CK   8'h04
`define DDRCD_BURST8_CK 3'h4
`define DDRCD_BURST4_CK 3'h2

`endif

// ===== core/ddrcd_link_if.sv
`include "ddrcd_defines.svh"

interface ddrcd_link_if;
    logic                     ck;
    logic                     reset_n;
    logic                     cke;
    logic                     cs_n;
    logic                     ras_n;
    logic                     cas_n;
    logic                     we_n;
    logic                     odt;
    logic [`DDRCD_BA_W-1:0]   ba;
    logic [`DDRCD_ADDR_W-1:0] addr;

    modport ctrl (output ck, reset_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr);
    modport mem  (input  ck, reset_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr);
endinterface : ddrcd_link_if

// ===== core/ddrcd_mem_end.sv
`include "ddrcd_defines.svh"

module ddrcd_mem_end (
    input  wire logic                     clk_sys_i,
    input  wire logic                     reset_n_i,
    ddrcd_link_if.mem                     link,
    output logic [`DDRCD_NCMD-1:0]        cmd_onehot_o,
    output logic [`DDRCD_BA_W-1:0]        cmd_ba_o,
    output logic [`DDRCD_ADDR_W-1:0]      cmd_addr_o,
    output logic                          cmd_ap_o,
    output logic                          cmd_bc4_o,
    output logic                          pd_o,
    output logic                          pd_active_o,
    output logic                          sref_o,
    output logic                          idle_o,
    output logic                          odt_en_o
);
    import ddrcd_pkg::*;

    // ---------------------------------------------------------------
    // pin sampling
    // ---------------------------------------------------------------
    logic [`DDRCD_SYNC_W-1:0] raw;
    logic [`DDRCD_SYNC_W-1:0] syn;
    logic                     ck_s;
    logic                     cke_s;
    logic                     cs_n_s;
    logic                     ras_n_s;
    logic                     cas_n_s;
    logic                     we_n_s;
    logic                     odt_s;
    logic [`DDRCD_BA_W-1:0]   ba_s;
    logic [`DDRCD_ADDR_W-1:0] addr_s;
    logic                     ck_d;
    logic                     ck_rise;

    assign raw = {link.ck, link.cke, link.cs_n, link.ras_n, link.cas_n, link.we_n,
                  link.odt, link.ba, link.addr};

    ddrcd_sync #(.WIDTH(`DDRCD_SYNC_W)) u_sync (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .d_i       (raw),
        .q_o       (syn)
    );

    assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, odt_s, ba_s, addr_s} = syn;
    assign ck_rise = ck_s & ~ck_d;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    ddrcd_pstate_type          pstate;
    logic                      cke_prev;
    logic [`DDRCD_NBANK-1:0]   banks;
    logic [2:0]                burst;
    logic                      ap_pend;
    logic [`DDRCD_BA_W-1:0]    ap_bank;
    logic [1:0]                mr0_bl;
    logic [7:0]                timer;
    ddrcd_cmd_type             pin_cmd;
    ddrcd_cmd_type             ev;
    logic                      ev_valid;
    logic                      idle_now;
    logic                      bc4_now;
    logic                      ap_close;

    // ---------------------------------------------------------------
    // command decode from sampled control pins
    // ---------------------------------------------------------------
    function automatic ddrcd_cmd_type decode_cmd(
        input logic cs_n,
        input logic ras_n,
        input logic cas_n,
        input logic we_n,
        input logic a10
    );
        ddrcd_cmd_type c;
        c = C_NOP;
        if (!cs_n) begin
            case ({ras_n, cas_n, we_n})
                3'h0:    c = C_MRS;
                3'h1:    c = C_REF;
                3'h2:    c = a10 ? C_PREA : C_PRE;
                3'h3:    c = C_ACT;
                3'h4:    c = C_WR;
                3'h5:    c = C_RD;
                3'h6:    c = a10 ? C_ZQCL : C_ZQCS;
                default: c = C_NOP;
            endcase
        end
        return c;
    endfunction : decode_cmd

    assign pin_cmd  = decode_cmd(cs_n_s, ras_n_s, cas_n_s, we_n_s, addr_s[`DDRCD_A10]);
    assign idle_now = (banks == '0) && (burst == 3'h0) && (timer == 8'h00);
    assign bc4_now  = (mr0_bl == `DDRCD_BL_OTF) ? ~addr_s[`DDRCD_A12]
                                                : (mr0_bl == `DDRCD_BL_FIX4);
    assign ap_close = ck_rise && (burst == 3'h1) && ap_pend;

    // ---------------------------------------------------------------
    // event selection per link clock rise; self-refresh exit on cke alone
    // ---------------------------------------------------------------
    always_comb begin
        ev       = C_NOP;
        ev_valid = 1'b0;
        if (pstate == PS_SREF) begin
            if (cke_s) begin
                ev       = C_SRX;
                ev_valid = 1'b1;
            end
        end else if (ck_rise) begin
            ev_valid = 1'b1;
            if (pstate == PS_PD) begin
                if (cke_s) begin
                    ev = (pin_cmd == C_NOP) ? C_PDX : C_BAD;
                end else begin
                    ev = C_NOP;
                end
            end else if (!cke_s && cke_prev) begin
                if (pin_cmd == C_REF) begin
                    ev = (idle_now && !cs_n_s) ? C_SRE : C_BAD;
                end else begin
                    ev = (pin_cmd == C_NOP) ? C_PDE : C_BAD;
                end
            end else if (!cke_prev || !cke_s) begin
                ev = C_NOP;
            end else if ((pin_cmd == C_RD || pin_cmd == C_WR) && burst != 3'h0) begin
                ev = C_BAD;
            end else if (pin_cmd != C_NOP && timer != 8'h00) begin
                ev = C_BAD;
            end else begin
                ev = pin_cmd;
            end
        end
    end

    // ---------------------------------------------------------------
    // power state
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge link.reset_n) begin
        if (!link.reset_n || !reset_n_i) begin
            pstate <= PS_PD;
        end else begin
            case (ev)
                C_SRE:   pstate <= PS_SREF;
                C_PDE:   pstate <= PS_PD;
                C_PDX:   pstate <= PS_AWAKE;
                C_SRX:   pstate <= PS_AWAKE;
                default: pstate <= pstate;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge link.reset_n) begin
        if (!link.reset_n || !reset_n_i) begin
            ck_d     <= 1'b0;
            cke_prev <= 1'b0;
        end else begin
            ck_d <= ck_s;
            if (ev == C_SRX) begin
                cke_prev <= 1'b1;
            end else if (ck_rise) begin
                cke_prev <= cke_s;
            end
        end
    end

    // ---------------------------------------------------------------
    // banks and bursts
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge link.reset_n) begin
        if (!link.reset_n || !reset_n_i) begin
            banks <= '0;
        end else begin
            if (ap_close) begin
                banks[ap_bank] <= 1'b0;
            end
            case (ev)
                C_ACT:   banks[ba_s] <= 1'b1;
                C_PRE:   banks[ba_s] <= 1'b0;
                C_PREA:  banks       <= '0;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge link.reset_n) begin
        if (!link.reset_n || !reset_n_i) begin
            burst   <= 3'h0;
            ap_pend <= 1'b0;
            ap_bank <= '0;
        end else if (ev == C_RD || ev == C_WR) begin
            burst   <= bc4_now ? `DDRCD_BURST4_CK : `DDRCD_BURST8_CK;
            ap_pend <= addr_s[`DDRCD_A10];
            ap_bank <= ba_s;
        end else if (ck_rise && burst != 3'h0) begin
            burst <= burst - 3'h1;
            if (burst == 3'h1) begin
                ap_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge link.reset_n) begin
        if (!link.reset_n || !reset_n_i) begin
            mr0_bl <= 2'h0;
        end else if (ev == C_MRS && ba_s == `DDRCD_MR0_BA) begin
            mr0_bl <= addr_s[`DDRCD_BL_LSB +: 2];
        end
    end

    // ---------------------------------------------------------------
    // busy timer for refresh, calibration, mode load and exits
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge link.reset_n) begin
        if (!link.reset_n || !reset_n_i) begin
            timer <= 8'h00;
        end else begin
            case (ev)
                C_REF:   timer <= `DDRCD_TRFC_CK;
                C_ZQCL:  timer <= `DDRCD_TZQL_CK;
                C_ZQCS:  timer <= `DDRCD_TZQS_CK;
                C_MRS:   timer <= `DDRCD_TMRD_CK;
                C_SRX:   timer <= `DDRCD_TXS_CK;
                C_PDX:   timer <= `DDRCD_TXP_CK;
                default: begin
                    // no refresh of its own while powered down
                    if (ck_rise && timer != 8'h00 && pstate != PS_PD) begin
                        timer <= timer - 8'h01;
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge link.reset_n) begin
        if (!link.reset_n || !reset_n_i) begin
            cmd_onehot_o <= '0;
            cmd_ba_o     <= '0;
            cmd_addr_o   <= '0;
            cmd_ap_o     <= 1'b0;
            cmd_bc4_o    <= 1'b0;
        end else begin
            cmd_onehot_o <= '0;
            if (ev_valid && ev != C_NOP) begin
                cmd_onehot_o <= `DDRCD_NCMD'(1) << ev;
                cmd_ba_o     <= ba_s;
                cmd_addr_o   <= addr_s;
                cmd_ap_o     <= addr_s[`DDRCD_A10];
                cmd_bc4_o    <= bc4_now;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge link.reset_n) begin
        if (!link.reset_n || !reset_n_i) begin
            pd_o        <= 1'b0;
            pd_active_o <= 1'b0;
            sref_o      <= 1'b0;
            idle_o      <= 1'b0;
            odt_en_o    <= 1'b0;
        end else begin
            pd_o        <= pstate == PS_PD;
            pd_active_o <= (pstate == PS_PD) && (banks != '0);
            sref_o      <= pstate == PS_SREF;
            idle_o      <= idle_now && cke_s && (pstate == PS_AWAKE);
            odt_en_o    <= odt_s && (pstate != PS_SREF);
        end
    end
endmodule : ddrcd_mem_end

// ===== core/ddrcd_pkg.sv
package ddrcd_pkg;

    typedef enum logic [3:0] {
        C_NOP, C_MRS, C_REF, C_SRE, C_SRX, C_PRE, C_PREA, C_ACT,
        C_WR, C_RD, C_ZQCL, C_ZQCS, C_PDE, C_PDX, C_BAD
    } ddrcd_cmd_type;

    typedef enum logic [1:0] {
        PS_AWAKE, PS_PD, PS_SREF
    } ddrcd_pstate_type;

endpackage : ddrcd_pkg

// ===== core/ddrcd_sync.sv
module ddrcd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    // ---------------------------------------------------------------
    // two-stage synchroniser, first stage feeds only the second
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule : ddrcd_sync

// ===== verification/ddrcd_link_properties.sv
module ddrcd_link_properties (
    input wire logic        clk_sys_i,
    input wire logic        reset_n_i,
    input wire logic        ck,
    input wire logic        reset_n,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [2:0]  ba,
    input wire logic [14:0] addr
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       ck_q, cke_q, cke_ck, in_sr;
    logic [1:0] n_hold;
    logic [4:0] n_xs;
    wire        ck_rise = ck & ~ck_q;
    wire        nop     = cs_n | (ras_n & cas_n & we_n);
    wire        ref_c   = ~cs_n & ~ras_n & ~cas_n & we_n;
    wire        rd_c    = ~cs_n & ras_n & ~cas_n & we_n;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    // link clock rises seen since the last cke change
    always_ff @(posedge clk_sys_i) begin
        ck_q   <= reset_n_i & ck;
        cke_q  <= reset_n_i & cke;
        n_hold <= !reset_n_i ? 2'h3 : (cke != cke_q) ? 2'h0 :
                  n_hold + {1'b0, ck_rise && n_hold != 2'h3};
    end
    // self-refresh tracking and rises since its exit edge
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            cke_ck <= 1'b0;
            in_sr  <= 1'b0;
            n_xs   <= 5'h10;
        end else if (ck_rise) begin
            cke_ck <= cke;
            in_sr  <= (!cke && cke_ck && ref_c) | (in_sr & ~cke);
            n_xs   <= (cke && !cke_ck && in_sr) ? 5'h00 : n_xs + {4'h0, n_xs != 5'h10};
        end
    end
    a_cke_hold_min: assert property ((cke != cke_q) |-> n_hold == 2'h3)
        else $error("cke changed too soon");
    a_exit_edge_nop: assert property (ck_rise && cke && !cke_ck |-> nop)
        else $error("command on cke rise");
    a_entry_edge_nop: assert property (ck_rise && !cke && cke_ck |-> nop || ref_c)
        else $error("command on cke fall");
    a_srx_quiet: assert property (ck_rise && n_xs < 5'h04 |-> nop)
        else $error("command during self-refresh exit");
    a_srx_no_read: assert property (ck_rise && n_xs < 5'h0f |-> !rd_c)
        else $error("read too soon after exit");
    a_mem_reset_high: assert property (reset_n_i && $past(reset_n_i) |-> reset_n)
        else $error("memory reset low in operation");
    a_pins_stand: assert property ($changed({cke, cs_n, ras_n, cas_n, we_n, ba, addr}) |-> $fell(ck))
        else $error("pins moved off the falling clock");
    a_ck_half: assert property ($changed(ck) |=> $stable(ck) [*7])
        else $error("link clock half period short");
endmodule : ddrcd_link_properties

// ===== verification/test_ddr3_command_cke_decoder.sv
module test_ddr3_command_cke_decoder;
    timeunit 1ns;
    timeprecision 100ps;
    import ddrcd_pkg::*;
    logic clk_sys_i = 1'b0, reset_n_i = 1'b0, req_valid = 1'b0, odt = 1'b1;
    ddrcd_cmd_type req_cmd = C_NOP;
    logic [2:0] req_ba = 3'h0, c_ba;
    logic [14:0] req_addr = 15'h0000, onehot, c_addr;
    logic taken, refused, c_ap, c_bc4, pd, pd_act, sref, idle, odt_en;
    int n_mismatch, check_count;
    ddrcd_link_if link ();
    ddrcd_ctrl_end ddrcd_ctrl_end_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .link(link.ctrl), .req_valid_i(req_valid), .req_cmd_i(req_cmd), .req_ba_i(req_ba),
        .req_addr_i(req_addr), .odt_i(odt), .req_taken_o(taken), .req_refused_o(refused));
    ddrcd_mem_end ddrcd_mem_end_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .link(link.mem), .cmd_onehot_o(onehot), .cmd_ba_o(c_ba), .cmd_addr_o(c_addr),
        .cmd_ap_o(c_ap), .cmd_bc4_o(c_bc4), .pd_o(pd), .pd_active_o(pd_act), .sref_o(sref),
        .idle_o(idle), .odt_en_o(odt_en));
    ddrcd_link_properties props (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ck(link.ck),
        .reset_n(link.reset_n), .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
        .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba), .addr(link.addr));
    always #5 clk_sys_i = ~clk_sys_i;
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick;
        @(posedge clk_sys_i);
        #1;
    endtask : tick
    // hold the request until the controller answers, then release it
    task automatic wait_answer;
        int i;
        for (i = 0; i < 400 && taken !== 1'b1 && refused !== 1'b1; i++) tick();
        req_valid = 1'b0;
        if (i == 400) begin
            n_mismatch++;
            close_out();
        end
    endtask : wait_answer
    // one request, its decoded pulse, then a gap longer than any busy time
    task automatic issue(input ddrcd_cmd_type c, input logic [2:0] b, input logic [14:0] a);
        int i;
        req_cmd = c;
        req_ba = b;
        req_addr = a;
        req_valid = 1'b1;
        wait_answer();
        chk("taken", 1'h1, taken);
        for (i = 0; i < 100 && onehot === 15'h0000; i++) tick();
        if (i == 100) begin
            n_mismatch++;
            close_out();
        end
        chk("command", 32'(15'h0001 << c), onehot);
        repeat (300) tick();
    endtask : issue
    task automatic t_bank;
        issue(C_MRS, 3'h0, 15'h0001);
        issue(C_ACT, 3'h5, 15'h1234);
        chk("bank", 3'h5, c_ba);
        chk("row", 15'h1234, c_addr);
        chk("idle", 1'h0, idle);
        issue(C_WR, 3'h5, 15'h0000);
        chk("chop", 1'h1, c_bc4);
        issue(C_RD, 3'h5, 15'h1400);
        chk("chop", 1'h0, c_bc4);
        chk("auto precharge", 1'h1, c_ap);
        issue(C_ACT, 3'h2, 15'h0003);
        issue(C_PRE, 3'h2, 15'h0000);
        chk("bank", 3'h2, c_ba);
        issue(C_PREA, 3'h0, 15'h0400);
        issue(C_ZQCL, 3'h0, 15'h0400);
        issue(C_ZQCS, 3'h0, 15'h0000);
        issue(C_MRS, 3'h0, 15'h0002);
        issue(C_ACT, 3'h1, 15'h0000);
        issue(C_RD, 3'h1, 15'h1400);
        chk("chop", 1'h1, c_bc4);
        issue(C_MRS, 3'h0, 15'h0000);
        issue(C_ACT, 3'h1, 15'h0000);
        issue(C_WR, 3'h1, 15'h0400);
        chk("chop", 1'h0, c_bc4);
        $display("t_bank done");
    endtask : t_bank
    task automatic t_sref;
        issue(C_REF, 3'h0, 15'h0000);
        issue(C_SRE, 3'h0, 15'h0000);
        chk("self refresh", 1'h1, sref);
        chk("termination", 1'h0, odt_en);
        issue(C_SRX, 3'h0, 15'h0000);
        chk("self refresh", 1'h0, sref);
        $display("t_sref done");
    endtask : t_sref
    task automatic t_power;
        repeat (2) tick();
        chk("power down", 1'h1, pd);
        chk("active kind", 1'h0, pd_act);
        issue(C_PDX, 3'h0, 15'h0000);
        chk("power down", 1'h0, pd);
        chk("idle", 1'h1, idle);
        chk("termination", 1'h1, odt_en);
        $display("t_power done");
    endtask : t_power
    task automatic t_refuse;
        req_cmd = C_BAD;
        req_valid = 1'b1;
        wait_answer();
        chk("refused", 1'h1, refused);
        chk("taken", 1'h0, taken);
        repeat (20) tick();
        $display("t_refuse done");
    endtask : t_refuse
    task automatic t_active_pd;
        issue(C_ACT, 3'h3, 15'h0007);
        issue(C_PDE, 3'h0, 15'h0000);
        chk("power down", 1'h1, pd);
        chk("active kind", 1'h1, pd_act);
        issue(C_PDX, 3'h0, 15'h0000);
        issue(C_PREA, 3'h0, 15'h0400);
        $display("t_active_pd done");
    endtask : t_active_pd
    initial begin
        repeat (12) @(posedge clk_sys_i);
        #1;
        reset_n_i = 1'b1;
        t_power();
        t_refuse();
        t_bank();
        t_sref();
        t_active_pd();
        close_out();
    end
endmodule : test_ddr3_command_cke_decoder
